/* File: src/uart_status_modem_regs.v */
// status, modem and control registers of one channel of a serial controller
// assumes an external receiver, transmit shifter and baud generator on clk
//
// Overview of operation
// - 16-mode interrupt pin floats when select low and control bit 3 clear.
// - in loopback, aux output 2 is the inverse of control bit 3.
// - control bit 4 enables local loopback; cleared by reset.
// - overrun interrupts at once; error tags interrupt when at hold position.
// - status bit 0 shows at least one received character waiting.
// - character arriving into a full fifo sets overrun and is dropped.
// - parity and framing flags belong to the character at the hold position.
// - break stores one character; indication lasts until line returns high.
// - hold-empty flag is set exactly while transmit holding/fifo is empty.
// - idle flag set only when holding/fifo and shifter are both empty.
// - status bit 7 set while any stored byte carries an error tag.
// - clear-to-send, set-ready, carrier deltas set on any input change.
// - ring delta sets only at the end of ringing.
// - any delta with modem interrupt enabled raises an interrupt.
// - clear-to-send inactive halts transmission after current character.
// - modem status high nibble shows inverted inputs or loopback bits.
// - scratch byte stores and returns host data, nothing else.
// - divisor is high byte over low byte, sixteen bits.
// - divisor loads 0x0001 only on power-up reset, not reset pin.
// - register reset values as listed, modem status deltas cleared.
// - pin reset levels: outputs high, transmit request low, interrupt idle.
// - control bits 0 and 1 drive terminal-ready and request-to-send low outside loopback; loopback holds both high.
// - in loopback, control bit 2 supplies the internal ring state.
`timescale 1ns/1ns
`include "uart_status_modem_regs_regs.vh"
module uart_status_modem_regs (
  input  wire        clk,
  input  wire        nrst,
  input  wire        npor,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg         hreadyout,
  output reg         hresp,
  output reg  [31:0] hrdata,
  input  wire        rx_char_done,
  input  wire [7:0]  rx_char_data,
  input  wire        rx_par_err,
  input  wire        rx_frm_err,
  input  wire        rx_brk,
  input  wire        tx_shifter_busy,
  input  wire        tx_line_in,
  output reg         tx_load,
  output reg  [7:0]  tx_data,
  input  wire        serial_in,
  output reg         serial_out,
  output reg         rx_line,
  input  wire        cts_in_n,
  input  wire        dsr_in_n,
  input  wire        call_alert_in_n,
  input  wire        carrier_in_n,
  input  wire        irq_drive_select,
  output reg         dtr_out_n,
  output reg         rts_out_n,
  output reg         loop_aux_out2,
  output reg         irq_out,
  output reg         irq_out_oe,
  output reg         irq68_n,
  output reg         rx_dma_req_n,
  output reg         tx_dma_req_n,
  output reg  [15:0] baud_divisor
);

// ========================================
// pin synchronisers
reg [5:0] sync_a;
reg [5:0] sync_b;
always @(posedge clk) begin
  sync_a <= {irq_drive_select, serial_in, carrier_in_n, call_alert_in_n, dsr_in_n, cts_in_n};
  sync_b <= sync_a;
end

// ========================================
// registers
reg [7:0] irq_enable_reg;
reg [7:0] fifo_setup_reg;
reg [7:0] line_format_reg;
reg [7:0] modem_control_reg;
reg [7:0] scratch_byte_reg;
reg [7:0] divisor_low_reg;
reg [7:0] divisor_high_reg;
reg [3:0] msr_delta;
reg [3:0] msr_prev;
reg       overrun;
reg       brk_active;
reg [10:0] rx_mem [0:15];
reg [3:0] rx_wp;
reg [3:0] rx_rp;
reg [4:0] rx_cnt;
reg [4:0] rx_err_cnt;
reg [7:0] tx_mem [0:15];
reg [3:0] tx_wp;
reg [3:0] tx_rp;
reg [4:0] tx_cnt;
reg       wr_pend;
reg       rd_pend;
reg [7:0] bus_addr;

wire       loop_on   = modem_control_reg[`MC_LOOP];
wire       fifo_on   = fifo_setup_reg[`FS_ENABLE];
wire [4:0] limit     = fifo_on ? `FIFO_DEPTH : `HOLD_DEPTH;
wire       line_hi   = loop_on ? tx_line_in : sync_b[4];

// ========================================
// modem status nibble
// inverted inputs or loopback
wire [3:0] msr_now = loop_on ?
  {modem_control_reg[`MC_IRQ_EN_OUT], modem_control_reg[`MC_AUX1],
   modem_control_reg[`MC_DTR], modem_control_reg[`MC_RTS]} : ~sync_b[3:0];
wire [3:0] msr_chg;
assign msr_chg[0] = msr_now[0] ^ msr_prev[0];
assign msr_chg[1] = msr_now[1] ^ msr_prev[1];
assign msr_chg[3] = msr_now[3] ^ msr_prev[3];
assign msr_chg[2] = msr_prev[2] & ~msr_now[2];
wire [7:0] msr_val = {msr_now, msr_delta};

// ========================================
// receive side
wire [10:0] rx_head   = rx_mem[rx_rp];
wire        rx_ready  = rx_cnt != 5'd0;
wire        rd_access = rd_pend;
wire        rx_pop    = rd_access && bus_addr == `OFS_DATA && rx_ready;
wire        rx_skip   = rx_brk && brk_active;
wire        rx_full   = rx_cnt >= limit;
wire        rx_push   = rx_char_done && !rx_full && !rx_skip;
wire        rx_ovr    = rx_char_done && rx_full && !rx_skip;
wire        push_err  = rx_push && (rx_par_err || rx_frm_err || rx_brk);
wire        pop_err   = rx_pop && rx_head[10:8] != 3'b000;
wire        rx_clr    = wr_pend && bus_addr == `OFS_IRQ_SRC &&
                        hwdata[`FS_ENABLE] && hwdata[`FS_RX_CLR];
wire        tx_clr    = wr_pend && bus_addr == `OFS_IRQ_SRC &&
                        hwdata[`FS_ENABLE] && hwdata[`FS_TX_CLR];

// ========================================
// transmit side
wire tx_push  = wr_pend && bus_addr == `OFS_DATA && tx_cnt < limit;
wire tx_start = tx_cnt != 5'd0 && !tx_shifter_busy && !tx_load && msr_now[0];

// ========================================
// line status
// data ready
wire hold_empty = tx_cnt == 5'd0;
wire tx_idle    = hold_empty && !tx_shifter_busy && !tx_load;
wire [7:0] lsr_val = {rx_err_cnt != 5'd0, tx_idle, hold_empty,
                      (rx_ready && rx_head[10]) || brk_active,
                      rx_ready && rx_head[9], rx_ready && rx_head[8],
                      overrun, rx_ready};

// ========================================
// interrupt source
// line status interrupt
wire line_evt = overrun || (rx_ready && rx_head[10:8] != 3'b000);
reg  [7:0] src_val;
always @* begin
  if (irq_enable_reg[`IE_LINE] && line_evt) begin
    src_val = `SRC_LINE;
  end else if (irq_enable_reg[`IE_RX] && rx_ready) begin
    src_val = `SRC_RX;
  end else if (irq_enable_reg[`IE_TX] && hold_empty) begin
    src_val = `SRC_TX;
  end else if (irq_enable_reg[`IE_MODEM] && msr_delta != 4'h0) begin
    src_val = `SRC_MODEM;
  end else begin
    src_val = `SRC_NONE;
  end
end
wire [7:0] isr_val = {fifo_on, fifo_on, src_val[5:0]};

// ========================================
// read mux
reg [7:0] rd_val;
always @* begin
  case (bus_addr)
    `OFS_DATA:       rd_val = rx_head[7:0];
    `OFS_IRQ_EN:     rd_val = irq_enable_reg;
    `OFS_IRQ_SRC:    rd_val = isr_val;
    `OFS_LINE_FMT:   rd_val = line_format_reg;
    `OFS_MODEM_CTL:  rd_val = modem_control_reg;
    `OFS_LINE_STAT:  rd_val = lsr_val;
    `OFS_MODEM_STAT: rd_val = msr_val;
    `OFS_SCRATCH:    rd_val = scratch_byte_reg;
    `OFS_DIV_LOW:    rd_val = divisor_low_reg;
    `OFS_DIV_HIGH:   rd_val = divisor_high_reg;
    default:         rd_val = 8'h00;
  endcase
end

// ========================================
// bus slave, reads take one wait state
wire take = hsel && htrans[1] && hready;
always @(posedge clk) begin
  if (!nrst) begin
    wr_pend   <= 1'b0;
    rd_pend   <= 1'b0;
    bus_addr  <= 8'h00;
    hreadyout <= 1'b1;
    hresp     <= 1'b0;
    hrdata    <= 32'h00000000;
  end else begin
    wr_pend <= take && hwrite;
    rd_pend <= take && !hwrite;
    if (take) begin
      bus_addr <= haddr[7:0];
    end
    hreadyout <= !(take && !hwrite);
    hresp     <= 1'b0;
    if (rd_pend) begin
      hrdata <= {24'h000000, rd_val};
    end
  end
end

// ========================================
// host written registers
// register reset values
always @(posedge clk) begin
  if (!nrst) begin
    irq_enable_reg    <= `RST_ZERO;
    fifo_setup_reg    <= `RST_ZERO;
    line_format_reg   <= `RST_ZERO;
    modem_control_reg <= `RST_ZERO;
    scratch_byte_reg  <= `RST_SCRATCH;
  end else if (wr_pend) begin
    case (bus_addr)
      `OFS_IRQ_EN:    irq_enable_reg    <= hwdata[7:0];
      `OFS_IRQ_SRC:   fifo_setup_reg    <= {hwdata[7:3], 2'b00, hwdata[0]};
      `OFS_LINE_FMT:  line_format_reg   <= hwdata[7:0];
      `OFS_MODEM_CTL: modem_control_reg <= {3'b000, hwdata[4:0]};
      `OFS_SCRATCH:   scratch_byte_reg  <= hwdata[7:0];
      default:        scratch_byte_reg  <= scratch_byte_reg;
    endcase
  end
end

// ========================================
// divisor, power-up reset only
// divisor untouched by reset pin
always @(posedge clk) begin
  if (!npor) begin
    divisor_low_reg  <= `RST_DIV_LOW;
    divisor_high_reg <= `RST_DIV_HIGH;
  end else if (wr_pend && bus_addr == `OFS_DIV_LOW) begin
    divisor_low_reg  <= hwdata[7:0];
  end else if (wr_pend && bus_addr == `OFS_DIV_HIGH) begin
    divisor_high_reg <= hwdata[7:0];
  end
end

// ========================================
// modem deltas and overrun
// clear on read, set wins
always @(posedge clk) begin
  if (!nrst) begin
    msr_delta <= 4'h0;
    msr_prev  <= msr_now;
    overrun   <= 1'b0;
  end else begin
    msr_prev <= msr_now;
    if (rd_access && bus_addr == `OFS_MODEM_STAT) begin
      msr_delta <= msr_chg;
    end else begin
      msr_delta <= msr_delta | msr_chg;
    end
    if (rx_ovr) begin
      overrun <= 1'b1;
    end else if (rd_access && bus_addr == `OFS_LINE_STAT) begin
      overrun <= 1'b0;
    end
  end
end

// ========================================
// receive fifo with error tags
always @(posedge clk) begin
  if (rx_push) begin
    rx_mem[rx_wp] <= {rx_brk, rx_frm_err, rx_par_err, rx_char_data};
  end
end
always @(posedge clk) begin
  if (!nrst || rx_clr) begin
    rx_wp      <= 4'h0;
    rx_rp      <= 4'h0;
    rx_cnt     <= 5'd0;
    rx_err_cnt <= 5'd0;
  end else begin
    if (rx_push) begin
      rx_wp <= rx_wp + 4'h1;
    end
    if (rx_pop) begin
      rx_rp <= rx_rp + 4'h1;
    end
    rx_cnt     <= rx_cnt + {4'h0, rx_push} - {4'h0, rx_pop};
    rx_err_cnt <= rx_err_cnt + {4'h0, push_err} - {4'h0, pop_err};
  end
end
always @(posedge clk) begin
  if (!nrst) begin
    brk_active <= 1'b0;
  end else if (rx_char_done && rx_brk) begin
    brk_active <= 1'b1;
  end else if (line_hi) begin
    brk_active <= 1'b0;
  end
end

// ========================================
// transmit fifo
always @(posedge clk) begin
  if (tx_push) begin
    tx_mem[tx_wp] <= hwdata[7:0];
  end
end
always @(posedge clk) begin
  if (!nrst || tx_clr) begin
    tx_wp   <= 4'h0;
    tx_rp   <= 4'h0;
    tx_cnt  <= 5'd0;
    tx_load <= 1'b0;
    tx_data <= 8'h00;
  end else begin
    tx_load <= tx_start;
    if (tx_start) begin
      tx_data <= tx_mem[tx_rp];
      tx_rp   <= tx_rp + 4'h1;
    end
    if (tx_push) begin
      tx_wp <= tx_wp + 4'h1;
    end
    tx_cnt <= tx_cnt + {4'h0, tx_push} - {4'h0, tx_start};
  end
end

// ========================================
// pins
// pin reset levels
always @(posedge clk) begin
  if (!nrst) begin
    serial_out    <= 1'b1;
    rx_line       <= 1'b1;
    dtr_out_n     <= 1'b1;
    rts_out_n     <= 1'b1;
    loop_aux_out2 <= 1'b1;
    irq_out       <= 1'b0;
    irq_out_oe    <= 1'b0;
    irq68_n       <= 1'b1;
    rx_dma_req_n  <= 1'b1;
    tx_dma_req_n  <= 1'b0;
    baud_divisor  <= {divisor_high_reg, divisor_low_reg};
  end else begin
    serial_out    <= loop_on | (tx_line_in & ~line_format_reg[6]);
    rx_line       <= line_hi;
    dtr_out_n     <= loop_on | ~modem_control_reg[`MC_DTR];
    rts_out_n     <= loop_on | ~modem_control_reg[`MC_RTS];
    loop_aux_out2 <= ~(loop_on & modem_control_reg[`MC_IRQ_EN_OUT]);
    irq_out       <= src_val != `SRC_NONE;
    irq_out_oe    <= sync_b[5] | modem_control_reg[`MC_IRQ_EN_OUT];
    irq68_n       <= src_val == `SRC_NONE;
    rx_dma_req_n  <= ~rx_ready;
    tx_dma_req_n  <= ~hold_empty;
    baud_divisor  <= {divisor_high_reg, divisor_low_reg};
  end
end

endmodule

/* File: src/uart_status_modem_regs_regs.vh */
// register offsets, field positions and reset values of one serial channel
// assumes a word-addressed AHB-Lite register window, byte-wide registers
`ifndef UART_STATUS_MODEM_REGS_REGS_VH
`define UART_STATUS_MODEM_REGS_REGS_VH
// ========================================
// offsets
`define OFS_DATA       8'h00
`define OFS_IRQ_EN     8'h04
`define OFS_IRQ_SRC    8'h08
`define OFS_LINE_FMT   8'h0C
`define OFS_MODEM_CTL  8'h10
`define OFS_LINE_STAT  8'h14
`define OFS_MODEM_STAT 8'h18
`define OFS_SCRATCH    8'h1C
`define OFS_DIV_LOW    8'h20
`define OFS_DIV_HIGH   8'h24
// ========================================
// reset values
`define RST_ZERO       8'h00
`define RST_IRQ_SRC    8'h01
`define RST_LINE_STAT  8'h60
`define RST_SCRATCH    8'hFF
`define RST_DIV_LOW    8'h01
`define RST_DIV_HIGH   8'h00
// ========================================
// field positions
`define MC_DTR         0
`define MC_RTS         1
`define MC_AUX1        2
`define MC_IRQ_EN_OUT  3
`define MC_LOOP        4
`define IE_RX          0
`define IE_TX          1
`define IE_LINE        2
`define IE_MODEM       3
`define FS_ENABLE      0
`define FS_RX_CLR      1
`define FS_TX_CLR      2
// ========================================
// interrupt source codes and fifo sizing
`define SRC_LINE       8'h06
`define SRC_RX         8'h04
`define SRC_TX         8'h02
`define SRC_MODEM      8'h00
`define SRC_NONE       8'h01
`define FIFO_DEPTH     5'd16
`define HOLD_DEPTH     5'd1
`endif

/* File: verif/uart_regs_checker.sv */
// checker: port-level rules of one serial channel
// assumes binding onto uart_status_modem_regs, one clock domain
`timescale 1ns/1ns
module uart_regs_checker (
  input logic        clk,
  input logic        nrst,
  input logic        npor,
  input logic        hsel,
  input logic [1:0]  htrans,
  input logic        hwrite,
  input logic        hready,
  input logic        hreadyout,
  input logic        hresp,
  input logic [31:0] hrdata,
  input logic        rx_char_done,
  input logic        rx_dma_req_n,
  input logic        tx_load,
  input logic        tx_shifter_busy,
  input logic        serial_out,
  input logic        dtr_out_n,
  input logic        rts_out_n,
  input logic        loop_aux_out2,
  input logic        irq_out,
  input logic        irq68_n,
  input logic        tx_dma_req_n
);
  // ========================================
  // properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence s_rd; hsel && htrans[1] && hready && !hwrite; endsequence
  sequence s_wr; hsel && htrans[1] && hready && hwrite; endsequence
  sequence s_wait; !hreadyout ##1 hreadyout; endsequence
  property p_rd; s_rd |=> s_wait; endproperty
  property p_wr; s_wr |=> hreadyout; endproperty
  property p_okay; !hresp && hrdata[31:8] == 24'h0; endproperty
  property p_rx_rdy; rx_char_done |-> ##[1:2] !rx_dma_req_n; endproperty
  property p_irq68; irq68_n != irq_out; endproperty
  property p_tx_gap; tx_load |-> !tx_shifter_busy ##1 !tx_load; endproperty
  property p_loop; !loop_aux_out2 |-> serial_out && dtr_out_n && rts_out_n; endproperty
  property p_rst;
    disable iff (!npor) !nrst |=> serial_out && rts_out_n && dtr_out_n && rx_dma_req_n && !tx_dma_req_n && irq68_n;
  endproperty
  a_rd: assert property (p_rd) else $error("read wait state wrong");
  a_wr: assert property (p_wr) else $error("write stalled");
  a_okay: assert property (p_okay) else $error("bad response or data");
  a_rx_rdy: assert property (p_rx_rdy) else $error("rx ready late");
  a_irq68: assert property (p_irq68) else $error("irq pins disagree");
  a_tx_gap: assert property (p_tx_gap) else $error("load while busy");
  a_loop: assert property (p_loop) else $error("loop pins not idle");
  a_rst: assert property (p_rst) else $error("pin reset level");
endmodule
bind uart_status_modem_regs uart_regs_checker u_chk (.clk(clk), .nrst(nrst), .npor(npor), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .rx_char_done(rx_char_done), .rx_dma_req_n(rx_dma_req_n), .tx_load(tx_load), .tx_shifter_busy(tx_shifter_busy),
  .serial_out(serial_out), .dtr_out_n(dtr_out_n), .rts_out_n(rts_out_n), .loop_aux_out2(loop_aux_out2),
  .irq_out(irq_out), .irq68_n(irq68_n), .tx_dma_req_n(tx_dma_req_n));

/* File: verif/tx_shifter_model.sv */
// model of the transmit shifter beside the channel
// assumes one load pulse per byte, frame of LEN cycles
`timescale 1ns/1ns
module tx_shifter_model #(parameter int LEN = 20) (
  input  logic       clk,
  input  logic       nrst,
  input  logic       tx_load,
  input  logic [7:0] tx_data,
  output logic       tx_shifter_busy,
  output logic       tx_line_in
);
  int         cnt;
  logic [9:0] frame;
  // ========================================
  // shifter
  always @(posedge clk) begin
    if (!nrst || cnt == 1) begin
      cnt <= 0;
      tx_shifter_busy <= 1'b0;
      tx_line_in <= 1'b1;
    end else if (tx_load) begin
      cnt <= LEN;
      frame <= {1'b1, tx_data, 1'b0};
      tx_shifter_busy <= 1'b1;
      tx_line_in <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      tx_line_in <= frame[cnt % 10];
    end
  end
endmodule

/* File: verif/tb.sv */
// testbench of one serial channel's status and modem registers
// assumes AHB-Lite single word transfers, shifter model on the far side
`timescale 1ns/1ns
module tb;
  logic        clk = 0, nrst = 0, npor = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic [1:0]  htrans = 0;
  logic        rx_char_done = 0, rx_par_err = 0, rx_frm_err = 0, rx_brk = 0, sin = 1, busy, tx_line_in, tx_load;
  logic [7:0]  rx_char_data = 0, tx_data, r;
  logic        cts_in_n = 1, dsr_in_n = 1, call_alert_in_n = 1, carrier_in_n = 1, irq_drive_select = 0;
  logic        serial_out, rx_line, dtr_out_n, rts_out_n, loop_aux_out2, irq_out, irq_out_oe, irq68_n;
  logic        rx_dma_req_n, tx_dma_req_n;
  logic [15:0] baud_divisor;
  int          fail_count = 0, compares = 0, cyc = 0;
  always #4 clk = ~clk;
  uart_status_modem_regs dut (.clk(clk), .nrst(nrst), .npor(npor), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_char_done(rx_char_done), .rx_char_data(rx_char_data), .rx_par_err(rx_par_err),
    .rx_frm_err(rx_frm_err), .rx_brk(rx_brk), .tx_shifter_busy(busy), .tx_line_in(tx_line_in), .tx_load(tx_load),
    .tx_data(tx_data), .serial_in(sin), .serial_out(serial_out), .rx_line(rx_line), .cts_in_n(cts_in_n),
    .dsr_in_n(dsr_in_n), .call_alert_in_n(call_alert_in_n), .carrier_in_n(carrier_in_n),
    .irq_drive_select(irq_drive_select), .dtr_out_n(dtr_out_n), .rts_out_n(rts_out_n),
    .loop_aux_out2(loop_aux_out2), .irq_out(irq_out), .irq_out_oe(irq_out_oe), .irq68_n(irq68_n),
    .rx_dma_req_n(rx_dma_req_n), .tx_dma_req_n(tx_dma_req_n), .baud_divisor(baud_divisor));
  tx_shifter_model sh (.clk(clk), .nrst(nrst), .tx_load(tx_load), .tx_data(tx_data), .tx_shifter_busy(busy),
    .tx_line_in(tx_line_in));
  // ========================================
  // helpers
  task automatic conclude;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= {24'h0, d};
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata[7:0];
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d); xfer(a, 1'b1, d); endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] e); xfer(a, 1'b0, 8'h00); chk(r, e); endtask
  task automatic settle; repeat (5) @(posedge clk); endtask
  task automatic rx(input logic [7:0] d, input logic p, input logic f, input logic b);
    @(posedge clk);
    rx_char_done <= 1'b1; rx_char_data <= d; rx_par_err <= p; rx_frm_err <= f; rx_brk <= b;
    @(posedge clk);
    rx_char_done <= 1'b0;
  endtask
  // ========================================
  // scenarios
  task automatic t_reset;
    rdc(8'h14, 8'h60); rdc(8'h1C, 8'hFF); rdc(8'h08, 8'h01); rdc(8'h10, 8'h00);
    rdc(8'h04, 8'h00); rdc(8'h0C, 8'h00); rdc(8'h18, 8'h00);
    rdc(8'h20, 8'h01); rdc(8'h24, 8'h00); chk(baud_divisor, 16'h0001);
    rdc(8'h40, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_store;
    wr(8'h1C, 8'hA5); rdc(8'h1C, 8'hA5);
    wr(8'h20, 8'h34); wr(8'h24, 8'h12); rdc(8'h24, 8'h12); chk(baud_divisor, 16'h1234);
    @(posedge clk) nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    rdc(8'h20, 8'h34); rdc(8'h1C, 8'hFF); chk(baud_divisor, 16'h1234);
    $display("test store done");
  endtask
  task automatic t_pins;
    wr(8'h10, 8'h03); settle; chk({dtr_out_n, rts_out_n, irq_out_oe}, 3'h0);
    wr(8'h10, 8'h08); settle; chk({dtr_out_n, rts_out_n, irq_out_oe}, 3'h7);
    wr(8'h10, 8'h00); irq_drive_select <= 1'b1; settle; chk(irq_out_oe, 1'h1);
    irq_drive_select <= 1'b0;
    wr(8'h10, 8'h1F); settle; chk({loop_aux_out2, serial_out, dtr_out_n, rts_out_n}, 4'h7);
    xfer(8'h18, 1'b0, 8'h00); chk(r & 8'hF0, 8'hF0);
    wr(8'h10, 8'h10); settle; chk(loop_aux_out2, 1'h1);
    xfer(8'h18, 1'b0, 8'h00); chk(r & 8'hF0, 8'h00);
    wr(8'h10, 8'h00); settle; xfer(8'h18, 1'b0, 8'h00); rdc(8'h18, 8'h00);
    $display("test pins done");
  endtask
  task automatic t_modem;
    wr(8'h04, 8'h08); cts_in_n <= 1'b0; settle;
    chk({irq_out, irq68_n}, 2'h2); rdc(8'h08, 8'h00);
    rdc(8'h18, 8'h11); rdc(8'h18, 8'h10); chk(irq_out, 1'h0);
    call_alert_in_n <= 1'b0; settle; rdc(8'h18, 8'h50);
    call_alert_in_n <= 1'b1; settle; rdc(8'h18, 8'h14);
    {dsr_in_n, carrier_in_n} <= 2'h0; settle; rdc(8'h18, 8'hBA);
    {dsr_in_n, carrier_in_n} <= 2'h3; settle; rdc(8'h18, 8'h1A);
    wr(8'h04, 8'h00);
    $display("test modem done");
  endtask
  task automatic t_rx;
    wr(8'h04, 8'h04); rx(8'h5A, 1'b1, 1'b0, 1'b0); settle;
    chk({irq_out, rx_dma_req_n}, 2'h2); rdc(8'h14, 8'hE5);
    rx(8'h3C, 1'b0, 1'b1, 1'b0); settle; rdc(8'h14, 8'hE7);
    rdc(8'h00, 8'h5A); rdc(8'h14, 8'h60); chk(irq_out, 1'h0);
    wr(8'h04, 8'h00);
    $display("test rx done");
  endtask
  task automatic t_fifo;
    wr(8'h08, 8'h01); rx(8'h11, 1'b0, 1'b0, 1'b0); rx(8'h22, 1'b0, 1'b1, 1'b0); settle;
    rdc(8'h14, 8'hE1);
    rdc(8'h00, 8'h11); rdc(8'h14, 8'hE9);
    rdc(8'h00, 8'h22); rdc(8'h14, 8'h60);
    rx(8'h33, 1'b0, 1'b0, 1'b0); wr(8'h08, 8'h03); rdc(8'h14, 8'h60);
    sin <= 1'b0; rx(8'h00, 1'b0, 1'b1, 1'b1); rx(8'h00, 1'b0, 1'b1, 1'b1); settle;
    rdc(8'h14, 8'hF9); chk(rx_line, 1'h0);
    rdc(8'h00, 8'h00); rdc(8'h14, 8'h70);
    sin <= 1'b1; settle; rdc(8'h14, 8'h60);
    sin <= 1'b0; wr(8'h10, 8'h10); settle; chk(rx_line, 1'h1);
    wr(8'h10, 8'h00); sin <= 1'b1; wr(8'h08, 8'h00);
    $display("test fifo done");
  endtask
  task automatic t_tx;
    int i;
    cts_in_n <= 1'b1; settle; xfer(8'h18, 1'b0, 8'h00);
    wr(8'h00, 8'h41); settle; rdc(8'h14, 8'h00); chk(tx_dma_req_n, 1'h1);
    cts_in_n <= 1'b0;
    for (i = 0; i < 50 && tx_load !== 1'b1; i++) @(posedge clk);
    chk(tx_data, 8'h41); rdc(8'h14, 8'h20);
    repeat (30) @(posedge clk);
    rdc(8'h14, 8'h60);
    $display("test tx done");
  endtask
  // ========================================
  // sequence and timeout
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      conclude;
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    npor <= 1'b1;
    t_reset; t_store; t_pins; t_modem; t_rx; t_fifo; t_tx;
    conclude;
  end
endmodule
